//--- cfg_bank.sv
// Converter configuration bank: serial write/readback port, register file,
// output pattern generator and a two-entry output buffer.
// Assumes serial pins and the format strap come from outside CLOCK_IN's domain;
// sample stream and overrange flag come from logic on CLOCK_IN.
`include "cfg_bank_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cfg_bank #(
  parameter int RESOLUTION = 14
) (
  input  wire logic                  CLOCK_IN,
  input  wire logic                  RESET_IN,
  input  wire logic                  SERIAL_SELECT_N_IN,
  input  wire logic                  SERIAL_CLOCK_IN,
  input  wire logic                  SERIAL_DATA_IN,
  input  wire logic                  FORMAT_STRAP_PIN_IN,
  input  wire logic                  OVERRANGE_IN,
  input  wire logic                  SAMPLE_VALID_IN,
  input  wire logic [RESOLUTION-1:0] SAMPLE_DATA_IN,
  output var  logic                  SAMPLE_READY_OUT,
  output var  logic                  DATA_VALID_OUT,
  output var  logic [RESOLUTION-1:0] DATA_OUT,
  input  wire logic                  DATA_READY_IN,
  output var  logic                  OVERRANGE_OR_READBACK_OUT,
  output var  logic [5:0]            SWING_CODE_OUT,
  output var  logic [1:0]            PERFORMANCE_BOOST_ONE_OUT,
  output var  logic                  PERFORMANCE_BOOST_TWO_OUT,
  output var  logic [3:0]            GAIN_CODE_OUT,
  output var  logic                  OUT_CLOCK_DRIVE_DOUBLE_OUT,
  output var  logic                  DATA_DRIVE_DOUBLE_OUT,
  output var  logic                  OFFSET_LOOP_ENABLE_OUT
);

  initial begin
    if (RESOLUTION != 14 && RESOLUTION != 12) begin
      $error("cfg_bank: RESOLUTION must be 12 or 14");
    end
  end

  // The register index is four bits wide
  initial begin
    if (`REG_COUNT > 16) begin
      $error("cfg_bank: register map exceeds the four-bit index");
    end
  end

  // Pin synchronisers: stage one feeds only stage two
  logic                    sel_n_s1_reg;
  logic                    sel_n_s2_reg;
  logic                    sclk_s1_reg;
  logic                    sclk_s2_reg;
  logic                    sclk_prev_reg;
  logic                    serial_data_in_s1_reg;
  logic                    serial_data_in_s2_reg;
  logic                    strap_s1_reg;
  logic                    strap_s2_reg;

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      sel_n_s1_reg  <= 1'b1;
      sel_n_s2_reg  <= 1'b1;
      sclk_s1_reg   <= 1'b0;
      sclk_s2_reg   <= 1'b0;
      sclk_prev_reg <= 1'b0;
      serial_data_in_s1_reg  <= 1'b0;
      serial_data_in_s2_reg  <= 1'b0;
    end else begin
      sel_n_s1_reg  <= SERIAL_SELECT_N_IN;
      sel_n_s2_reg  <= sel_n_s1_reg;
      sclk_s1_reg   <= SERIAL_CLOCK_IN;
      sclk_s2_reg   <= sclk_s1_reg;
      sclk_prev_reg <= sclk_s2_reg;
      serial_data_in_s1_reg  <= SERIAL_DATA_IN;
      serial_data_in_s2_reg  <= serial_data_in_s1_reg;
    end
  end

  // The strap is a static level; two stages only keep metastability out
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
    end else begin
      strap_s1_reg <= FORMAT_STRAP_PIN_IN;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // Data and clock share the same latency, so data sampled at the detected edge
  // is the bit that stood at the pin edge; hold time covers the sync delay.
  logic sclk_fall;
  assign sclk_fall = sclk_prev_reg & ~sclk_s2_reg & ~sel_n_s2_reg;

  // Serial framing
  cfg_bank_pkg::frame_state_t state_reg;
  logic [3:0]                 bit_cnt_reg;
  logic [14:0]                shift_reg;
  logic [15:0]                frame_word;
  logic                       frame_done;

  assign frame_word = {shift_reg, serial_data_in_s2_reg};
  assign frame_done = sclk_fall && (bit_cnt_reg == `FRAME_BITS);

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      state_reg   <= cfg_bank_pkg::FRAME_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 15'h0000;
    end else begin
      case (state_reg)
        cfg_bank_pkg::FRAME_IDLE: begin
          bit_cnt_reg <= 4'h0;
          if (!sel_n_s2_reg) begin
            state_reg <= cfg_bank_pkg::FRAME_SHIFT;
          end
        end
        cfg_bank_pkg::FRAME_SHIFT: begin
          if (sel_n_s2_reg) begin
            // A partial word at select release is dropped
            state_reg <= cfg_bank_pkg::FRAME_IDLE;
          end else if (sclk_fall) begin
            shift_reg   <= frame_word[14:0];
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        default: begin
          state_reg <= cfg_bank_pkg::FRAME_IDLE;
        end
      endcase
    end
  end

  // Register file
  function automatic logic [4:0] reg_lookup(input logic [7:0] addr);
    logic [4:0] hit;
    hit = 5'h00;
    case (addr)
      `ADDR_CTRL:      hit = {1'b1, `IDX_CTRL};
      `ADDR_SWING:     hit = {1'b1, `IDX_SWING};
      `ADDR_PERF1:     hit = {1'b1, `IDX_PERF1};
      `ADDR_GAIN_PAT:  hit = {1'b1, `IDX_GAIN_PAT};
      `ADDR_DRIVE:     hit = {1'b1, `IDX_DRIVE};
      `ADDR_FORMAT:    hit = {1'b1, `IDX_FORMAT};
      `ADDR_CUST_HI:   hit = {1'b1, `IDX_CUST_HI};
      `ADDR_CUST_LO:   hit = {1'b1, `IDX_CUST_LO};
      `ADDR_IFACE:     hit = {1'b1, `IDX_IFACE};
      `ADDR_LATENCY:   hit = {1'b1, `IDX_LATENCY};
      `ADDR_PDN_SWING: hit = {1'b1, `IDX_PDN_SWING};
      `ADDR_PERF2:     hit = {1'b1, `IDX_PERF2};
      `ADDR_PEDESTAL:  hit = {1'b1, `IDX_PEDESTAL};
      `ADDR_LOOP:      hit = {1'b1, `IDX_LOOP};
      `ADDR_LOW_SPEED: hit = {1'b1, `IDX_LOW_SPEED};
      default:         hit = 5'h00;
    endcase
    return hit;
  endfunction

  cfg_bank_pkg::cfg_byte_t cfg_reg [0:`REG_COUNT-1];
  logic [4:0]              wr_hit;
  logic                    readback_on;
  logic                    soft_reset;
  logic                    wr_allowed;

  assign wr_hit      = reg_lookup(frame_word[15:8]);
  assign readback_on = cfg_reg[`IDX_CTRL][`BIT_READBACK];
  // Register zero stays writable so readback mode can be left
  assign wr_allowed  = wr_hit[4] && (!readback_on || wr_hit[3:0] == `IDX_CTRL);
  assign soft_reset  = frame_done && wr_allowed && wr_hit[3:0] == `IDX_CTRL
                       && frame_word[`BIT_SOFT_RESET];

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN || soft_reset) begin
      // Soft reset clears its own bit too, so it never reads back as one
      for (int i = 0; i < `REG_COUNT; i++) begin
        cfg_reg[i] <= `REG_RESET;
      end
    end else if (frame_done && wr_allowed) begin
      cfg_reg[wr_hit[3:0]] <= frame_word[7:0];
    end
  end

  // Readback shifter: loaded after the eighth address bit, MSB first,
  // moves on each later falling edge so the controller samples it on the next.
  logic [4:0] rd_hit;
  logic [7:0] rd_shift_reg;
  logic [7:0] rd_byte;

  assign rd_hit  = reg_lookup(frame_word[7:0]);
  // Register zero and unmapped addresses read as zero
  always_comb begin
    if (rd_hit[4] && rd_hit[3:0] != `IDX_CTRL) begin
      rd_byte = cfg_reg[rd_hit[3:0]];
    end else begin
      rd_byte = `REG_RESET;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      rd_shift_reg <= 8'h00;
    end else if (sclk_fall && state_reg == cfg_bank_pkg::FRAME_SHIFT) begin
      if (bit_cnt_reg == `ADDR_LAST_BIT) begin
        rd_shift_reg <= rd_byte;
      end else begin
        rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      OVERRANGE_OR_READBACK_OUT <= 1'b0;
    end else if (readback_on) begin
      OVERRANGE_OR_READBACK_OUT <= rd_shift_reg[7];
    end else begin
      OVERRANGE_OR_READBACK_OUT <= OVERRANGE_IN;
    end
  end

  // Field decode to registered controls
  logic [1:0] swing_enable;
  logic [1:0] fmt_sel;
  logic       gain_active;

  assign swing_enable = cfg_reg[`IDX_PDN_SWING][`SWING_EN_HI:`SWING_EN_LO];
  assign fmt_sel      = cfg_reg[`IDX_FORMAT][`FMT_HI:`FMT_LO];
  assign gain_active  = !cfg_reg[`IDX_GAIN_PAT][`BIT_GAIN_BYPASS]
                        && cfg_reg[`IDX_LATENCY][`BIT_NO_LOW_LAT];

  // Gated controls: the analog side sees the default until the gate opens
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      SWING_CODE_OUT <= `SWING_DEFAULT;
      GAIN_CODE_OUT  <= `GAIN_NONE;
    end else begin
      SWING_CODE_OUT <= (swing_enable == `SWING_EN_ON)
                        ? cfg_reg[`IDX_SWING][`SWING_HI:`SWING_LO]
                        : `SWING_DEFAULT;
      GAIN_CODE_OUT <= gain_active ? cfg_reg[`IDX_GAIN_PAT][`GAIN_HI:`GAIN_LO]
                                   : `GAIN_NONE;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      PERFORMANCE_BOOST_ONE_OUT  <= 2'h0;
      PERFORMANCE_BOOST_TWO_OUT  <= 1'b0;
      OUT_CLOCK_DRIVE_DOUBLE_OUT <= 1'b0;
      DATA_DRIVE_DOUBLE_OUT      <= 1'b0;
      OFFSET_LOOP_ENABLE_OUT     <= 1'b0;
    end else begin
      // Undefined codes 01/10 are passed through unchanged for the analog side
      PERFORMANCE_BOOST_ONE_OUT  <= cfg_reg[`IDX_PERF1][`PERF1_HI:`PERF1_LO];
      PERFORMANCE_BOOST_TWO_OUT  <= cfg_reg[`IDX_PERF2][`BIT_PERF2];
      OUT_CLOCK_DRIVE_DOUBLE_OUT <= cfg_reg[`IDX_DRIVE][`BIT_CLK_DRIVE];
      DATA_DRIVE_DOUBLE_OUT      <= cfg_reg[`IDX_DRIVE][`BIT_DATA_DRIVE];
      OFFSET_LOOP_ENABLE_OUT     <= cfg_reg[`IDX_FORMAT][`BIT_OFFSET_LOOP];
    end
  end

  // Pattern generator
  localparam logic [RESOLUTION-1:0] TOGGLE_WORD = RESOLUTION'({(RESOLUTION/2){2'b01}});

  logic [2:0]            pattern;
  logic                  sample_take;
  logic                  toggle_phase_reg;
  logic [RESOLUTION-1:0] ramp_reg;
  logic [1:0]            ramp_step_reg;
  logic [13:0]           custom_word;
  logic                  twos_out;
  logic [RESOLUTION-1:0] word_next;

  assign pattern     = cfg_reg[`IDX_GAIN_PAT][`PAT_HI:`PAT_LO];
  assign custom_word = {cfg_reg[`IDX_CUST_HI], cfg_reg[`IDX_CUST_LO][`CUST_LO_HI:`CUST_LO_LO]};
  assign sample_take = SAMPLE_VALID_IN && SAMPLE_READY_OUT;

  always_comb begin
    case (fmt_sel)
      `FMT_TWOS:   twos_out = 1'b1;
      `FMT_OFFSET: twos_out = 1'b0;
      default:     twos_out = !strap_s2_reg;
    endcase
  end

  always_comb begin
    case (pattern)
      // Samples arrive offset binary; twos complement flips the sign bit
      `PAT_NORMAL: word_next = SAMPLE_DATA_IN ^ {twos_out, {(RESOLUTION-1){1'b0}}};
      `PAT_ZEROS:  word_next = '0;
      `PAT_ONES:   word_next = '1;
      `PAT_TOGGLE: word_next = toggle_phase_reg ? ~TOGGLE_WORD : TOGGLE_WORD;
      `PAT_RAMP:   word_next = ramp_reg;
      `PAT_CUSTOM: word_next = custom_word[13 -: RESOLUTION];
      default:     word_next = '0;
    endcase
  end

  // Pattern state steps once per accepted sample, so a stall holds the sequence
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN || soft_reset) begin
      toggle_phase_reg <= 1'b0;
    end else if (sample_take) begin
      toggle_phase_reg <= (pattern == `PAT_TOGGLE) ? !toggle_phase_reg : 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN || soft_reset) begin
      ramp_reg         <= '0;
      ramp_step_reg    <= 2'h0;
    end else if (sample_take) begin
      if (pattern != `PAT_RAMP) begin
        ramp_reg      <= '0;
        ramp_step_reg <= 2'h0;
      end else if (RESOLUTION == 14) begin
        ramp_reg <= ramp_reg + 1'b1;
      end else begin
        ramp_step_reg <= ramp_step_reg + 2'h1;
        if (ramp_step_reg == `NARROW_STEP_LAST) begin
          ramp_reg <= ramp_reg + 1'b1;
        end
      end
    end
  end

  // Two-entry output buffer: head drives the outputs, spare catches a word
  // accepted in the cycle the receiver stalls.
  logic [RESOLUTION-1:0] spare_data_reg;
  logic                  spare_valid_reg;
  logic                  head_free;
  logic                  spare_valid_next;

  assign head_free        = !DATA_VALID_OUT || DATA_READY_IN;

  always_comb begin
    if (spare_valid_reg) begin
      spare_valid_next = !head_free;
    end else begin
      spare_valid_next = sample_take && !head_free;
    end
  end

  // Ready is registered, so it drops one word late: the spare absorbs that word
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      spare_valid_reg  <= 1'b0;
      SAMPLE_READY_OUT <= 1'b0;
    end else begin
      spare_valid_reg  <= spare_valid_next;
      SAMPLE_READY_OUT <= !spare_valid_next;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      DATA_VALID_OUT   <= 1'b0;
      DATA_OUT         <= '0;
      spare_data_reg   <= '0;
    end else begin
      if (head_free) begin
        if (spare_valid_reg) begin
          DATA_OUT       <= spare_data_reg;
          DATA_VALID_OUT <= 1'b1;
        end else begin
          DATA_VALID_OUT <= sample_take;
          if (sample_take) begin
            DATA_OUT <= word_next;
          end
        end
      end else if (sample_take) begin
        spare_data_reg <= word_next;
      end
    end
  end

endmodule

`default_nettype wire

//--- cfg_bank_params.svh
// Constants of the converter configuration bank: addresses, fields, codes, reset values.
// Assumes inclusion by the bank's design file and its verification files.
//
// Contract
// - Writing one to soft reset bit clears every register, then bit reads zero.
// - Readback bit zero shows over-range on shared pin; one shifts register contents.
// - Register one bits seven to two hold six-bit output swing code.
// - Swing code applies only while swing override field is set.
// - Gain field bits seven to four of 25h, half-decibel steps to 1100.
// - Gain applies only with bypass clear and low latency disabled.
// - Pattern 000 normal data, 001 all zeros, 010 all ones.
// - Pattern 011 alternates 0101 pattern and its complement each sample.
// - Pattern 100 wide variant ramps one code per sample, wraps after 16383.
// - Pattern 100 narrow variant ramps one code every fourth sample to 4095.
// - Pattern 101 outputs custom word from 3Fh and 40h; 110/111 unused.
// - Register 26h bit one doubles output clock buffer drive.
// - Register 26h bit zero doubles all data output buffer drive.
// - Format field 3Dh bits 7:6: 00 strap, 10 twos complement, 11 offset.
// - One serial write updates all fields of that register together.
// - After reset every register holds 00h.
// - Frames of sixteen bits on clock falling edges, select low, address first.
// - In readback mode writes to all registers except zero are ignored.
// - Register 3Dh bit five enables the offset correction loop.
`ifndef CFG_BANK_PARAMS_SVH
`define CFG_BANK_PARAMS_SVH

`define REG_COUNT        15
`define REG_RESET        8'h00
`define FRAME_BITS       4'hF
`define ADDR_LAST_BIT    4'h7

`define ADDR_CTRL        8'h00
`define ADDR_SWING       8'h01
`define ADDR_PERF1       8'h03
`define ADDR_GAIN_PAT    8'h25
`define ADDR_DRIVE       8'h26
`define ADDR_FORMAT      8'h3D
`define ADDR_CUST_HI     8'h3F
`define ADDR_CUST_LO     8'h40
`define ADDR_IFACE       8'h41
`define ADDR_LATENCY     8'h42
`define ADDR_PDN_SWING   8'h43
`define ADDR_PERF2       8'h4A
`define ADDR_PEDESTAL    8'hBF
`define ADDR_LOOP        8'hCF
`define ADDR_LOW_SPEED   8'hDF

`define IDX_CTRL         4'h0
`define IDX_SWING        4'h1
`define IDX_PERF1        4'h2
`define IDX_GAIN_PAT     4'h3
`define IDX_DRIVE        4'h4
`define IDX_FORMAT       4'h5
`define IDX_CUST_HI      4'h6
`define IDX_CUST_LO      4'h7
`define IDX_IFACE        4'h8
`define IDX_LATENCY      4'h9
`define IDX_PDN_SWING    4'hA
`define IDX_PERF2        4'hB
`define IDX_PEDESTAL     4'hC
`define IDX_LOOP         4'hD
`define IDX_LOW_SPEED    4'hE

`define BIT_READBACK     0
`define BIT_SOFT_RESET   1
`define SWING_HI         7
`define SWING_LO         2
`define PERF1_HI         1
`define PERF1_LO         0
`define GAIN_HI          7
`define GAIN_LO          4
`define BIT_GAIN_BYPASS  3
`define PAT_HI           2
`define PAT_LO           0
`define BIT_CLK_DRIVE    1
`define BIT_DATA_DRIVE   0
`define FMT_HI           7
`define FMT_LO           6
`define BIT_OFFSET_LOOP  5
`define BIT_NO_LOW_LAT   3
`define SWING_EN_HI      1
`define SWING_EN_LO      0
`define BIT_PERF2        0
`define CUST_LO_HI       7
`define CUST_LO_LO       2

`define SWING_EN_ON      2'h3
`define FMT_TWOS         2'h2
`define FMT_OFFSET       2'h3
`define GAIN_NONE        4'h0
`define SWING_DEFAULT    6'h00

`define PAT_NORMAL       3'h0
`define PAT_ZEROS        3'h1
`define PAT_ONES         3'h2
`define PAT_TOGGLE       3'h3
`define PAT_RAMP         3'h4
`define PAT_CUSTOM       3'h5
`define NARROW_STEP_LAST 2'h3

`endif

//--- cfg_bank_pkg.sv
// Types used by the configuration bank's framing logic and register file.
// Assumes nothing of its surroundings.
package cfg_bank_pkg;
  typedef logic [7:0] cfg_byte_t;
  typedef enum logic [0:0] {
    FRAME_IDLE,
    FRAME_SHIFT
  } frame_state_t;
endpackage

//--- cfg_bank_assertions.sv
// Port checker for the configuration bank, attached by bind.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cfg_bank_assertions #(
  parameter int RESOLUTION = 14
) (
  input wire logic                  CLOCK_IN,
  input wire logic                  RESET_IN,
  input wire logic                  SERIAL_SELECT_N_IN,
  input wire logic                  SAMPLE_VALID_IN,
  input wire logic                  SAMPLE_READY_OUT,
  input wire logic                  DATA_VALID_OUT,
  input wire logic [RESOLUTION-1:0] DATA_OUT,
  input wire logic                  DATA_READY_IN,
  input wire logic [5:0]            SWING_CODE_OUT,
  input wire logic [3:0]            GAIN_CODE_OUT,
  input wire logic                  OFFSET_LOOP_ENABLE_OUT
);
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RESET_IN);
  AST_RESET_ZERO: assert property (
    $fell(RESET_IN) |-> !DATA_VALID_OUT && !SAMPLE_READY_OUT && GAIN_CODE_OUT == 4'h0
      && SWING_CODE_OUT == 6'h00 && !OFFSET_LOOP_ENABLE_OUT)
    else $error("outputs not clear after reset");
  AST_READY_RISE: assert property (
    $fell(RESET_IN) |-> ##[1:3] SAMPLE_READY_OUT)
    else $error("sample ready late after reset");
  // Eight idle cycles cover the select synchroniser and the commit delay
  AST_QUIET_LINK: assert property (
    SERIAL_SELECT_N_IN [*8] |=> $stable(GAIN_CODE_OUT) && $stable(SWING_CODE_OUT)
      && $stable(OFFSET_LOOP_ENABLE_OUT))
    else $error("control output moved while the link was idle");
  AST_HOLD_WORD: assert property (
    DATA_VALID_OUT && !DATA_READY_IN |=> DATA_VALID_OUT && $stable(DATA_OUT))
    else $error("output word dropped while stalled");
  AST_TAKE_SAMPLE: assert property (
    SAMPLE_VALID_IN && SAMPLE_READY_OUT |=> DATA_VALID_OUT)
    else $error("accepted sample not presented");
  AST_SPARE_FULL: assert property (
    $fell(SAMPLE_READY_OUT) |-> DATA_VALID_OUT)
    else $error("ready fell with the head entry empty");
  AST_SPARE_FREE: assert property (
    DATA_VALID_OUT && DATA_READY_IN && !SAMPLE_READY_OUT |-> ##[1:2] SAMPLE_READY_OUT)
    else $error("ready not restored after a take");
  AST_WORD_CAUSE: assert property (
    $rose(DATA_VALID_OUT) |-> $past(SAMPLE_VALID_IN) && $past(SAMPLE_READY_OUT))
    else $error("output word without an accepted sample");
endmodule
bind cfg_bank cfg_bank_assertions #(.RESOLUTION(RESOLUTION)) u_cfg_bank_assertions (
  .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .SERIAL_SELECT_N_IN(SERIAL_SELECT_N_IN),
  .SAMPLE_VALID_IN(SAMPLE_VALID_IN), .SAMPLE_READY_OUT(SAMPLE_READY_OUT),
  .DATA_VALID_OUT(DATA_VALID_OUT), .DATA_OUT(DATA_OUT), .DATA_READY_IN(DATA_READY_IN),
  .SWING_CODE_OUT(SWING_CODE_OUT), .GAIN_CODE_OUT(GAIN_CODE_OUT),
  .OFFSET_LOOP_ENABLE_OUT(OFFSET_LOOP_ENABLE_OUT));
`default_nettype wire

//--- cfg_host.sv
// Serial controller model for the bank's select, clock and data pins.
// Assumes one caller at a time; half period 62.5 ns.
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
  output var logic sel_n_out,
  output var logic sclk_out,
  output var logic serial_data_in_out,
  input  wire logic rb_in
);
  initial begin
    sel_n_out = 1'b1;
    sclk_out = 1'b0;
    serial_data_in_out = 1'b0;
  end
  // Clock stands low between frames; readback sampled on falling edges
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    begin
      w = {a, d};
      q = 8'h00;
      sel_n_out = 1'b0;
      #62.5;
      for (int i = 15; i >= 0; i--) begin
        serial_data_in_out = w[i];
        sclk_out = 1'b1;
        #62.5;
        sclk_out = 1'b0;
        if (i < 8) q = {q[6:0], rb_in};
        #62.5;
      end
      sel_n_out = 1'b1;
      // A released line must not keep its last level
      serial_data_in_out = ~serial_data_in_out;
      #62.5;
    end
  endtask
endmodule
`default_nettype wire

//--- tb_cfg_bank.sv
// Self-checking bench: serial writes and readback, stream, patterns.
// Assumes cfg_bank at RESOLUTION 14 with its checker bound.
`timescale 1ns/1ps
`default_nettype none
module tb_cfg_bank;
  logic        clk, rst, strap, ovr, sv, rdy, s_rdy, dv, ror, pb2, cdd, ddd, ole;
  logic [13:0] sd;
  logic [13:0] dout;
  logic [5:0]  swing;
  logic [1:0]  pb1;
  logic [3:0]  gain;
  wire logic   sel_n, sclk, sdi;
  int          n_errors, checks;
  logic [13:0] got[$];
  logic [7:0]  regs [14] = '{8'h01, 8'h03, 8'h25, 8'h26, 8'h3D, 8'h3F, 8'h40,
                             8'h41, 8'h42, 8'h43, 8'h4A, 8'hBF, 8'hCF, 8'hDF};
  cfg_bank #(.RESOLUTION(14)) u_cfg_bank (
    .CLOCK_IN(clk), .RESET_IN(rst), .SERIAL_SELECT_N_IN(sel_n), .SERIAL_CLOCK_IN(sclk),
    .SERIAL_DATA_IN(sdi), .FORMAT_STRAP_PIN_IN(strap), .OVERRANGE_IN(ovr),
    .SAMPLE_VALID_IN(sv), .SAMPLE_DATA_IN(sd), .SAMPLE_READY_OUT(s_rdy),
    .DATA_VALID_OUT(dv), .DATA_OUT(dout), .DATA_READY_IN(rdy),
    .OVERRANGE_OR_READBACK_OUT(ror), .SWING_CODE_OUT(swing),
    .PERFORMANCE_BOOST_ONE_OUT(pb1), .PERFORMANCE_BOOST_TWO_OUT(pb2),
    .GAIN_CODE_OUT(gain), .OUT_CLOCK_DRIVE_DOUBLE_OUT(cdd),
    .DATA_DRIVE_DOUBLE_OUT(ddd), .OFFSET_LOOP_ENABLE_OUT(ole));
  cfg_host u_cfg_host (.sel_n_out(sel_n), .sclk_out(sclk), .serial_data_in_out(sdi), .rb_in(ror));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (dv === 1'b1 && rdy === 1'b1) got.push_back(dout);
  end
  task wrap_up;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e, input string m);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Frames start 1.1 ns after a falling edge so no link edge meets a clock edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    @(negedge clk);
    #1.1;
    u_cfg_host.xfer(a, d, q);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    @(negedge clk);
    #1.1;
    u_cfg_host.xfer(a, 8'h00, q);
    checks++;
    if (q !== e) begin
      n_errors++;
      $display("mismatch at %0t: readback %h got %h exp %h", $time, a, q, e);
    end
  endtask
  task put(input logic [13:0] d);
    int k;
    sv = 1'b1;
    sd = d;
    k = 0;
    while (s_rdy !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    if (k == 50) begin
      n_errors++;
      $display("mismatch at %0t: sample not taken", $time);
      wrap_up;
    end
    @(negedge clk);
  endtask
  function automatic logic [13:0] exp_word(input logic [2:0] c, input int i, input logic f);
    case (c)
      3'h0: return (14'h0123 + 14'(i)) ^ {f, 13'h0000};
      3'h2: return 14'h3FFF;
      3'h3: return i[0] ? 14'h2AAA : 14'h1555;
      3'h4: return 14'(i);
      3'h5: return 14'h2972;
      default: return 14'h0000;
    endcase
  endfunction
  function automatic logic [15:0] outs();
    return {swing, pb1, pb2, gain, cdd, ddd, ole};
  endfunction
  task stream(input logic [2:0] c, input logic f, input int n);
    got.delete();
    @(negedge clk);
    for (int i = 0; i < n; i++) put(14'h0123 + 14'(i));
    sv = 1'b0;
    repeat (4) @(negedge clk);
    chk(16'(got.size()), 16'(n), "word count");
    for (int i = 0; i < n && i < got.size(); i++) begin
      chk({2'b00, got[i]}, {2'b00, exp_word(c, i, f)}, "word");
    end
  endtask
  task t_reset;
    chk(outs(), 16'h0000, "control after reset");
    wr(8'h00, 8'h01);
    foreach (regs[j]) rd(regs[j], 8'h00);
    rd(8'h02, 8'h00);
    wr(8'h00, 8'h00);
  endtask
  task t_fields;
    wr(8'h03, 8'h03);
    wr(8'h4A, 8'h01);
    wr(8'h26, 8'h02);
    wr(8'h3D, 8'h20);
    wr(8'h01, 8'h6C);
    chk(outs(), 16'h0385, "fields");
    wr(8'h43, 8'h03);
    chk({10'h000, swing}, 16'h001B, "swing");
    wr(8'h26, 8'h01);
    chk({14'h0000, cdd, ddd}, 16'h0001, "drive");
    wr(8'h02, 8'hFF);
    wr(8'hC0, 8'hFF);
    chk(outs(), 16'h6F83, "unmapped write");
    wr(8'h25, 8'hC0);
    chk({12'h000, gain}, 16'h0000, "gain, low latency");
    wr(8'h42, 8'h08);
    chk({12'h000, gain}, 16'h000C, "gain");
    wr(8'h25, 8'hC8);
    chk({12'h000, gain}, 16'h0000, "gain bypass");
  endtask
  task t_readback;
    ovr = 1'b1;
    repeat (3) @(negedge clk);
    chk({15'h0000, ror}, 16'h0001, "overrange");
    wr(8'h00, 8'h01);
    wr(8'h26, 8'h02);
    rd(8'h26, 8'h01);
    rd(8'h3D, 8'h20);
    wr(8'h00, 8'h00);
    chk({14'h0000, cdd, ddd}, 16'h0001, "write in readback");
    ovr = 1'b0;
    repeat (3) @(negedge clk);
    chk({15'h0000, ror}, 16'h0000, "overrange clear");
  endtask
  task t_soft;
    wr(8'h00, 8'h02);
    chk(outs(), 16'h0000, "soft reset");
    wr(8'h26, 8'h01);
    chk({14'h0000, cdd, ddd}, 16'h0001, "write after soft reset");
    wr(8'h00, 8'h01);
    rd(8'h01, 8'h00);
    wr(8'h00, 8'h00);
  endtask
  task t_patterns;
    wr(8'h3F, 8'hA5);
    wr(8'h40, 8'hC8);
    for (int c = 1; c < 8; c++) begin
      wr(8'h25, 8'(c));
      stream(3'(c), 1'b0, c == 4 ? 16386 : 8);
    end
    wr(8'h25, 8'h00);
    for (int j = 0; j < 4; j++) begin
      strap = (j == 3);
      wr(8'h3D, j == 0 ? 8'h80 : j == 1 ? 8'hC0 : 8'h00);
      stream(3'h0, ~j[0], 8);
    end
  endtask
  // Receiver stalls: the two entries fill, then drain in order
  task t_stall;
    int acc;
    wr(8'h3D, 8'hC0);
    got.delete();
    rdy = 1'b0;
    acc = 0;
    @(negedge clk);
    sv = 1'b1;
    sd = 14'h0AAA;
    repeat (6) begin
      if (s_rdy === 1'b1) acc++;
      @(negedge clk);
      sd = 14'h0AAA + 14'(acc);
    end
    sv = 1'b0;
    chk(16'(acc), 16'h0002, "buffer depth");
    rdy = 1'b1;
    repeat (4) @(negedge clk);
    chk({dv, 13'h0000, 2'(got.size())}, 16'h0002, "drained");
    chk({2'b00, got[0]}, 16'h0AAA, "first word");
    chk({2'b00, got[1]}, 16'h0AAB, "second word");
  endtask
  initial begin
    {rst, strap, ovr, sv, rdy, sd} = {5'b10001, 14'h0000};
    n_errors = 0;
    checks = 0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset;
    t_fields;
    t_readback;
    t_soft;
    t_patterns;
    t_stall;
    wrap_up;
  end
endmodule
`default_nettype wire
